// *** agc_control_register_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - soft power-down at one holds control logic, bias and oscillator inactive
// - soft power-down at zero enables control logic, bias and oscillator
// - over-current event sets the fault flag, which stays set
// - host writing zero to the fault bit clears it
// - over-temperature is deglitched then latched into the thermal bit
// - host writing zero to the thermal bit clears it
// - squelch enable high activates the noise gate, low deactivates it
// - noise gate stays off while compression ratio is 1:1
// - gain decreases spaced at least attack code times 0.1067 ms
// - release code is six bits, reset value 001011
// - gain increases spaced at least release code times 0.0137 s
// - after a decrease wait hold code times 0.0137 s before increasing
// - hold code zero, the reset value, disables the hold wait
// - fixed gain is six-bit two's complement, -28 dB to +30 dB
// - function control has power-down at bit 5, fault at bit 3
// - bus address 0xB0 for writes and 0xB1 for reads
module agc_control_register_bank
    import agc_pkg::*;
#(
    parameter int ATK_UNIT = ATTACK_UNIT_CYCLES,
    parameter int REL_UNIT = RELEASE_UNIT_CYCLES,
    parameter int DEGLITCH = THERMAL_DEGLITCH_CYCLES
)(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic over_current_in,
    input wire logic over_temp_in,
    input wire logic compression_is_unity,
    input wire logic gain_drop_request,
    input wire logic gain_rise_request,
    output logic gain_drop_allow,
    output logic gain_rise_allow,
    output logic core_active,
    output logic amp_enable,
    output logic squelch_active,
    output logic [5:0] gain_drop_interval,
    output logic [5:0] gain_rise_interval,
    output logic [5:0] hold_interval,
    output logic [5:0] base_gain
);
    // the timer limits are 32-bit products of a 6-bit code and a unit count
    if (ATK_UNIT < 1 || REL_UNIT < 1 || REL_UNIT > 32'd34000000 || ATK_UNIT > 32'd34000000
        || DEGLITCH < 1 || DEGLITCH > 65535)
    begin : g_check
        $error("agc_control_register_bank: unsupported timing parameter");
    end

    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic oc_s1, oc_s2, temp_s1, temp_s2;
    logic scl_rise, scl_fall, start_det, stop_det;
    i2c_state_e state;
    logic [7:0] sh, rd_sh, ptr, wr_addr, wr_data, rd_value;
    logic [2:0] bit_cnt;
    logic full, rw, nack, wr_en;
    logic amp_en_bit, soft_powerdown, fault_flag, thermal_flag, squelch_enable;
    logic [15:0] deglitch_cnt;
    logic temp_hot;
    logic [31:0] since_drop, since_rise, drop_limit, rise_limit, hold_limit;
    logic drop_taken, rise_taken, wr_func;

    // two-stage synchronisers; only the second stage and the scl_d/sda_d delay copies feed anything else
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
            {oc_s1, oc_s2, temp_s1, temp_s2} <= 4'h0;
        end
        else
        begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            oc_s1 <= over_current_in;
            oc_s2 <= oc_s1;
            temp_s1 <= over_temp_in;
            temp_s2 <= temp_s1;
        end
    end

    // bus conditions seen at the ref_clk rate; scl must stay under ref_clk/8
    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;

    // read mux: unused bits read fixed, unmapped addresses read zero
    always_comb
    begin
        rd_value = 8'h00;
        case (ptr)
            REG_FUNC: rd_value = FUNC_FIXED_ONES | {1'b0, amp_en_bit, soft_powerdown, 1'b0,
                                 fault_flag, thermal_flag, 1'b0, squelch_enable};
            REG_ATTACK: rd_value = {2'b00, gain_drop_interval};
            REG_RELEASE: rd_value = {2'b00, gain_rise_interval};
            REG_HOLD: rd_value = {2'b00, hold_interval};
            REG_GAIN: rd_value = {2'b00, base_gain};
            default: rd_value = 8'h00;
        endcase
    end

    // bus slave: sample on scl rise, drive sda only after scl falls
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            sh <= 8'h00;
            rd_sh <= 8'h00;
            ptr <= 8'h00;
            bit_cnt <= 3'h0;
            full <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            wr_en <= 1'b0;
            if (start_det)
            begin
                state <= ST_ADDR;
                bit_cnt <= 3'h0;
                full <= 1'b0;
                sda_oe <= 1'b0;
            end
            else if (stop_det)
            begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                unique case (state)
                    ST_ADDR, ST_REG, ST_WDATA:
                    begin
                        sh <= {sh[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 3'h1;
                        full <= (bit_cnt == 3'h7);
                    end
                    ST_ACK_RDATA: nack <= sda_s2;
                    ST_IDLE, ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WDATA, ST_RDATA: ;
                endcase
            end
            else if (scl_fall)
            begin
                unique case (state)
                    ST_IDLE: ;
                    ST_ADDR:
                        if (full)
                        begin
                            full <= 1'b0;
                            if (sh[7:1] == I2C_DEV_ADDR)
                            begin
                                rw <= sh[0];
                                sda_oe <= 1'b1;
                                state <= ST_ACK_ADDR;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    ST_ACK_ADDR:
                        if (rw)
                        begin
                            rd_sh <= rd_value;
                            sda_oe <= ~rd_value[7];
                            bit_cnt <= 3'h0;
                            state <= ST_RDATA;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            state <= ST_REG;
                        end
                    ST_REG:
                        if (full)
                        begin
                            full <= 1'b0;
                            ptr <= sh;
                            sda_oe <= 1'b1;
                            state <= ST_ACK_REG;
                        end
                    ST_ACK_REG, ST_ACK_WDATA:
                    begin
                        sda_oe <= 1'b0;
                        if (state == ST_ACK_WDATA)
                            ptr <= ptr + 8'h01;
                        state <= ST_WDATA;
                    end
                    ST_WDATA:
                        if (full)
                        begin
                            full <= 1'b0;
                            wr_en <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= sh;
                            sda_oe <= 1'b1;
                            state <= ST_ACK_WDATA;
                        end
                    ST_RDATA:
                        if (bit_cnt == 3'h7)
                        begin
                            sda_oe <= 1'b0;
                            ptr <= ptr + 8'h01; // pointer moves once the byte is out
                            state <= ST_ACK_RDATA;
                        end
                        else
                        begin
                            bit_cnt <= bit_cnt + 3'h1;
                            rd_sh <= {rd_sh[6:0], 1'b0};
                            sda_oe <= ~rd_sh[6];
                        end
                    ST_ACK_RDATA:
                        if (nack)
                            state <= ST_IDLE;
                        else
                        begin
                            // next byte must show its top bit before the next scl rise
                            rd_sh <= rd_value;
                            sda_oe <= ~rd_value[7];
                            bit_cnt <= 3'h0;
                            state <= ST_RDATA;
                        end
                endcase
            end
        end
    end

    assign wr_func = wr_en & (wr_addr == REG_FUNC);

    // function control; hardware set wins over a clearing write
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            amp_en_bit <= FUNC_RESET[AMP_EN_BIT];
            soft_powerdown <= FUNC_RESET[POWERDOWN_BIT];
            fault_flag <= FUNC_RESET[FAULT_BIT];
            thermal_flag <= FUNC_RESET[THERMAL_BIT];
            squelch_enable <= FUNC_RESET[SQUELCH_BIT];
        end
        else
        begin
            if (wr_func)
            begin
                amp_en_bit <= wr_data[AMP_EN_BIT];
                soft_powerdown <= wr_data[POWERDOWN_BIT];
                squelch_enable <= wr_data[SQUELCH_BIT];
            end
            if (oc_s2)
                fault_flag <= 1'b1;
            else if (wr_func && !wr_data[FAULT_BIT])
                fault_flag <= 1'b0;
            if (temp_hot)
                thermal_flag <= 1'b1;
            else if (wr_func && !wr_data[THERMAL_BIT])
                thermal_flag <= 1'b0;
        end
    end

    // timing and gain codes; top bits are dropped on write
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gain_drop_interval <= ATTACK_RESET;
            gain_rise_interval <= RELEASE_RESET;
            hold_interval <= HOLD_RESET;
            base_gain <= GAIN_RESET;
        end
        else if (wr_en)
        begin
            if (wr_addr == REG_ATTACK)
                gain_drop_interval <= wr_data[5:0];
            if (wr_addr == REG_RELEASE)
                gain_rise_interval <= wr_data[5:0];
            if (wr_addr == REG_HOLD)
                hold_interval <= wr_data[5:0];
            if (wr_addr == REG_GAIN)
            begin
                // codes below -28 dB are clamped rather than stored
                if ($signed(wr_data[5:0]) < GAIN_MIN)
                    base_gain <= GAIN_MIN;
                else if ($signed(wr_data[5:0]) > GAIN_MAX)
                    base_gain <= GAIN_MAX;
                else
                    base_gain <= wr_data[5:0];
            end
        end
    end

    // over-temperature must persist DEGLITCH cycles before it counts
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            deglitch_cnt <= 16'h0000;
            temp_hot <= 1'b0;
        end
        else if (!temp_s2)
        begin
            deglitch_cnt <= 16'h0000;
            temp_hot <= 1'b0;
        end
        else if (deglitch_cnt == 16'(DEGLITCH - 1))
            temp_hot <= 1'b1;
        else
            deglitch_cnt <= deglitch_cnt + 16'h0001;
    end

    // limits follow the live codes, so a rewrite acts on the next decision
    assign drop_limit = 32'(gain_drop_interval) * 32'(ATK_UNIT);
    assign rise_limit = 32'(gain_rise_interval) * 32'(REL_UNIT);
    assign hold_limit = 32'(hold_interval) * 32'(REL_UNIT);
    assign drop_taken = gain_drop_request & gain_drop_allow;
    assign rise_taken = gain_rise_request & gain_rise_allow;

    // step timers saturate; frozen during power-down
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            since_drop <= TIMER_MAX;
            since_rise <= TIMER_MAX;
        end
        else if (!soft_powerdown)
        begin
            if (drop_taken)
                since_drop <= 32'h00000000;
            else if (since_drop != TIMER_MAX)
                since_drop <= since_drop + 32'h00000001;
            if (rise_taken)
                since_rise <= 32'h00000000;
            else if (since_rise != TIMER_MAX)
                since_rise <= since_rise + 32'h00000001;
        end
    end

    // registered status; a step taken now blocks the same kind next cycle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gain_drop_allow <= 1'b0;
            gain_rise_allow <= 1'b0;
            core_active <= 1'b0;
            amp_enable <= 1'b0;
            squelch_active <= 1'b0;
        end
        else
        begin
            core_active <= ~soft_powerdown;
            amp_enable <= amp_en_bit & ~soft_powerdown & ~temp_hot;
            squelch_active <= squelch_enable & ~compression_is_unity & ~soft_powerdown;
            gain_drop_allow <= ~soft_powerdown & ~drop_taken & (since_drop >= drop_limit);
            gain_rise_allow <= ~soft_powerdown & ~rise_taken & ~drop_taken
                & (since_rise >= rise_limit) & (since_drop >= hold_limit);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_drop_step;
        drop_taken && gain_drop_interval != 6'h00;
    endsequence

    a_powerdown_core:
        assert property (soft_powerdown |=> !core_active && !gain_drop_allow && !gain_rise_allow)
        else $error("core active during power-down");
    a_wake_core:
        assert property (!soft_powerdown |=> core_active)
        else $error("core inactive after power-up");
    a_fault_set:
        assert property (oc_s2 |=> fault_flag [*1] ##0 (fault_flag || wr_func))
        else $error("fault flag not set");
    a_fault_clear:
        assert property (wr_func && !wr_data[FAULT_BIT] && !oc_s2 |=> !fault_flag)
        else $error("fault flag not cleared");
    a_thermal_hold:
        assert property (temp_hot |=> thermal_flag)
        else $error("thermal flag not latched");
    a_thermal_clear:
        assert property (wr_func && !wr_data[THERMAL_BIT] && !temp_hot |=> !thermal_flag)
        else $error("thermal flag not cleared");
    a_squelch_on:
        assert property (squelch_enable && !compression_is_unity && !soft_powerdown
            |=> squelch_active)
        else $error("noise gate not active");
    a_squelch_unity:
        assert property (compression_is_unity |=> !squelch_active)
        else $error("noise gate active at unity ratio");
    a_drop_spacing:
        assert property (s_drop_step |=> !gain_drop_allow [*2])
        else $error("gain decrease allowed too soon");
    a_hold_block:
        assert property (drop_taken && hold_interval != 6'h00 |=> !gain_rise_allow [*2])
        else $error("gain increase inside hold time");
    a_unused_zero:
        assert property (wr_en && wr_addr == REG_ATTACK
            |=> gain_drop_interval == wr_data[5:0])
        else $error("attack code not taken from low bits");
    a_gain_range:
        assert property ($signed(base_gain) >= GAIN_MIN && $signed(base_gain) <= GAIN_MAX)
        else $error("fixed gain out of range");
endmodule
`default_nettype wire

// *** agc_control_register_bank_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, got) begin checks_done++; \
    if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module agc_control_register_bank_test;
    import agc_pkg::*;
    // small units keep the step timers short
    localparam int ATK_U = 4;
    localparam int REL_U = 8;
    localparam int DEG = 4;
    localparam int LIMIT = 40000;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic over_current_in = 1'b0;
    logic over_temp_in = 1'b0;
    logic compression_is_unity = 1'b0;
    logic gain_drop_request = 1'b0;
    logic gain_rise_request = 1'b0;
    logic scl, sda, sda_out, sda_oe, gain_drop_allow, gain_rise_allow;
    logic core_active, amp_enable, squelch_active;
    logic [5:0] gain_drop_interval, gain_rise_interval, hold_interval, base_gain;
    logic [31:0] seed = 32'hBC8785DD;
    int regs[8];
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    agc_control_register_bank #(.ATK_UNIT(ATK_U), .REL_UNIT(REL_U), .DEGLITCH(DEG))
        agc_control_register_bank_i (.ref_clk, .rstn, .scl_in(scl), .sda_in(sda),
        .sda_out, .sda_oe, .over_current_in, .over_temp_in, .compression_is_unity,
        .gain_drop_request, .gain_rise_request, .gain_drop_allow, .gain_rise_allow,
        .core_active, .amp_enable, .squelch_active, .gain_drop_interval,
        .gain_rise_interval, .hold_interval, .base_gain);
    agc_i2c_host agc_i2c_host_i (.ref_clk, .sda_oe, .scl, .sda);

    initial forever #10 ref_clk = ~ref_clk;

    // a hang is cut short here
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // register model: sticky flags only clear on a written zero
    function automatic void mdl_write(input int a, input int d);
        int g;
        case (a)
            1: regs[1] = 8'h82 | (d & 8'h61) | (regs[1] & d & 8'h0C);
            2, 3, 4: regs[a] = d & 8'h3F;
            5:
            begin
                g = d & 8'h3F;
                if (g > 31) g = g - 64;
                if (g < -28) g = -28;
                if (g > 30) g = 30;
                regs[5] = g & 8'h3F;
            end
            default: ;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic rd(input int a);
        logic [7:0] d;
        agc_i2c_host_i.reg_read(a[7:0], d);
        `CHECK("register read", (a >= 1 && a <= 5) ? regs[a] : 0, d)
    endtask

    task automatic wr(input int a, input int d);
        logic ok;
        agc_i2c_host_i.reg_write(a[7:0], d[7:0], ok);
        mdl_write(a, d);
        `CHECK("write ack", 1'b1, ok)
    endtask

    // one step request, then cycles until the watched allow returns
    task automatic gap(input logic do_drop, input logic see_drop, output int n);
        n = 0;
        while (!(do_drop ? gain_drop_allow : gain_rise_allow) && n < 6000)
        begin
            @(negedge ref_clk);
            n++;
        end
        gain_drop_request = do_drop;
        gain_rise_request = !do_drop;
        @(negedge ref_clk);
        gain_drop_request = 1'b0;
        gain_rise_request = 1'b0;
        n = 1;
        while (n < 6000 && (n < 3 || !(see_drop ? gain_drop_allow : gain_rise_allow)))
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        int n;
        logic ack;
        logic [15:0] pair;
        regs = '{0, 8'hC3, 8'h05, 8'h0B, 8'h00, 8'h06, 0, 0};
        cyc(8);
        rstn = 1'b1;
        cyc(4);
        for (int a = 1; a <= 7; a++) rd(a);
        `CHECK("squelch on", 1'b1, squelch_active)
        compression_is_unity = 1'b1;
        cyc(3);
        `CHECK("squelch at unity", 1'b0, squelch_active)
        compression_is_unity = 1'b0;
        agc_i2c_host_i.probe(8'hB2, ack);
        `CHECK("foreign address", 1'b0, ack)
        // clamp cases first, then random codes with junk in bits 7:6
        for (int k = 0; k < 10; k++)
        begin
            seed = xorshift(seed);
            wr(k < 2 ? 5 : 2 + k % 4, k == 0 ? 8'hE3 : k == 1 ? 8'h5F : seed[7:0]);
            rd(k < 2 ? 5 : 2 + k % 4);
            `CHECK("codes", {regs[2][5:0], regs[3][5:0], regs[4][5:0], regs[5][5:0]}, {gain_drop_interval, gain_rise_interval, hold_interval, base_gain})
        end
        // a host reading on after its ack must get the following register
        agc_i2c_host_i.reg_read_pair(8'h02, pair);
        `CHECK("read pair", {regs[2][7:0], regs[3][7:0]}, pair)
        // a glitch shorter than the deglitch time must not latch
        over_temp_in = 1'b1;
        cyc(2);
        over_temp_in = 1'b0;
        cyc(4);
        rd(1);
        over_current_in = 1'b1;
        over_temp_in = 1'b1;
        cyc(DEG + 6);
        `CHECK("amp off when hot", 1'b0, amp_enable)
        over_current_in = 1'b0;
        over_temp_in = 1'b0;
        regs[1] |= 8'h0C;
        cyc(4);
        rd(1);
        wr(1, 8'hCF);
        rd(1);
        wr(1, 8'hC3);
        rd(1);
        // software shutdown and wake
        wr(1, 8'hE3);
        cyc(3);
        `CHECK("powered down", 3'b000, {core_active, squelch_active, gain_drop_allow})
        wr(1, 8'hC3);
        cyc(3);
        `CHECK("awake", 3'b111, {core_active, squelch_active, amp_enable})
        wr(1, 8'hC2);
        cyc(3);
        `CHECK("squelch off", 1'b0, squelch_active)
        // step spacing
        wr(2, 3);
        gap(1'b1, 1'b1, n);
        `CHECK("drop gap 3", 1'b1, n >= 3 * ATK_U + 1 && n <= 3 * ATK_U + 4)
        wr(2, 5);
        gap(1'b1, 1'b1, n);
        `CHECK("drop gap 5", 1'b1, n >= 5 * ATK_U + 1 && n <= 5 * ATK_U + 4)
        wr(3, 2);
        gap(1'b0, 1'b0, n);
        `CHECK("rise gap", 1'b1, n >= 2 * REL_U + 1 && n <= 2 * REL_U + 4)
        wr(4, 3);
        gap(1'b1, 1'b0, n);
        `CHECK("hold gap", 1'b1, n >= 3 * REL_U + 1 && n <= 3 * REL_U + 4)
        wr(4, 0);
        gap(1'b1, 1'b0, n);
        `CHECK("no hold", 1'b1, n <= 4)
        `CHECK("sda out level", 1'b0, sda_out)
        give_verdict();
    end
endmodule
`default_nettype wire

// *** agc_i2c_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// bus host: scl driven by us, sda open drain with a pull-up
module agc_i2c_host (
    input wire logic ref_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic pull_low = 1'b0;

    // wired-and of both parties; nobody pulling means the pull-up wins
    assign sda = !(pull_low || sda_oe);
    initial scl = 1'b1;

    // one 80 ns phase of the bus clock; a whole bit takes 180 ns
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask

    // also serves as repeated start
    task automatic start_cond();
        pull_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        pull_low = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        @(negedge ref_clk);
        pull_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        pull_low = 1'b0;
        half();
    endtask

    // data moves a cycle after scl falls so it never reads as start or stop
    task automatic bit_cycle(input logic b, output logic seen);
        @(negedge ref_clk);
        pull_low = !b;
        half();
        scl = 1'b1;
        half();
        seen = sda;
        scl = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
        bit_cycle(1'b1, s);
        ack = !s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
        bit_cycle(last, s); // nack on the last byte ends the read
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start_cond();
        put_byte(8'hB0, k0);
        put_byte(a, k1);
        put_byte(d, k2);
        stop_cond();
        ok = k0 && k1 && k2;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic k;
        start_cond();
        put_byte(8'hB0, k);
        put_byte(a, k);
        start_cond();
        put_byte(8'hB1, k);
        get_byte(1'b1, d);
        stop_cond();
    endtask

    // two bytes in one read; the host acks the first and nacks the second
    task automatic reg_read_pair(input logic [7:0] a, output logic [15:0] d);
        logic k;
        start_cond();
        put_byte(8'hB0, k);
        put_byte(a, k);
        start_cond();
        put_byte(8'hB1, k);
        get_byte(1'b0, d[15:8]);
        get_byte(1'b1, d[7:0]);
        stop_cond();
    endtask

    task automatic probe(input logic [7:0] b, output logic ack);
        start_cond();
        put_byte(b, ack);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// *** agc_pkg.sv ***
`default_nettype none
package agc_pkg;
    // bus address: 0xB0 for writes, 0xB1 for reads
    localparam logic [6:0] I2C_DEV_ADDR = 7'h58;

    // register addresses
    localparam logic [7:0] REG_FUNC = 8'h01;
    localparam logic [7:0] REG_ATTACK = 8'h02;
    localparam logic [7:0] REG_RELEASE = 8'h03;
    localparam logic [7:0] REG_HOLD = 8'h04;
    localparam logic [7:0] REG_GAIN = 8'h05;

    // function control layout and values after reset
    localparam int AMP_EN_BIT = 6;
    localparam int POWERDOWN_BIT = 5;
    localparam int FAULT_BIT = 3;
    localparam int THERMAL_BIT = 2;
    localparam int SQUELCH_BIT = 0;
    localparam logic [7:0] FUNC_FIXED_ONES = 8'h82;
    localparam logic [7:0] FUNC_RESET = 8'hC3;
    localparam logic [5:0] ATTACK_RESET = 6'h05;
    localparam logic [5:0] RELEASE_RESET = 6'h0B;
    localparam logic [5:0] HOLD_RESET = 6'h00;
    localparam logic [5:0] GAIN_RESET = 6'h06;
    localparam logic signed [5:0] GAIN_MIN = 6'sh24;
    localparam logic signed [5:0] GAIN_MAX = 6'sh1E;

    // timing
    localparam real CLK_PERIOD_NS = 20.0;
    localparam real ATTACK_STEP_MS = 0.1067;
    localparam real RELEASE_STEP_S = 0.0137;
    localparam int ATTACK_UNIT_CYCLES = int'($ceil(ATTACK_STEP_MS * 1.0e6 / CLK_PERIOD_NS - 1.0e-6));
    localparam int RELEASE_UNIT_CYCLES = int'($ceil(RELEASE_STEP_S * 1.0e9 / CLK_PERIOD_NS - 1.0e-6));
    localparam int THERMAL_DEGLITCH_CYCLES = 16;
    localparam logic [31:0] TIMER_MAX = 32'hFFFFFFFF;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
        ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_ACK_RDATA
    } i2c_state_e;
endpackage
`default_nettype wire
